/* lai_pkg.sv */
// constants, types and helpers shared by the light adc integration timing block
package lai_pkg;

  // axi4-lite bus shape
  localparam int ADDR_W = 8;                       // byte address width
  localparam int DATA_W = 32;                      // data width

  // register indices (byte address is four times the index)
  localparam logic [ADDR_W-1:0] IDX_CMD   = 8'h00; // command register
  localparam logic [ADDR_W-1:0] IDX_CTRL  = 8'h01; // control register (range)
  localparam logic [ADDR_W-1:0] IDX_TIMER = 8'h06; // timer counter value
  localparam logic [ADDR_W-1:0] IDX_SYNC  = 8'h08; // sync strobe register
  localparam logic [ADDR_W-1:0] IDX_STAT  = 8'h09; // integration status
  localparam int              IDX_SHIFT = 2;     // index to byte address shift

  // field positions
  localparam int CMD_EN_BIT    = 7;                // converter enable
  localparam int CMD_MODE_BIT  = 5;                // 0 internal, 1 external timing
  localparam int CMD_DSEL_LSB  = 2;                // diode select, two bits
  localparam int CMD_WID_LSB   = 0;                // width code, two bits
  localparam int CTRL_RNG_LSB  = 2;                // range code, two bits
  localparam int SYNC_BIT      = 0;                // write one to sync
  localparam int STAT_ACT_BIT  = 0;                // integration running
  localparam int STAT_IR_BIT   = 1;                // ir diode being integrated
  localparam int STAT_FULL_BIT = 2;                // oscillator at full rate
  localparam int STAT_SAT_BIT  = 3;                // last count hit capacity

  // reset values
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // cycle counter capacity, two to the sixteenth
  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] CNT_CAP = 17'h10000;

  // width codes
  typedef enum logic [1:0] {
    LAI_WID_16 = 2'h0,
    LAI_WID_12 = 2'h1,
    LAI_WID_8  = 2'h2,
    LAI_WID_4  = 2'h3
  } lai_width_t;

  // range codes, range one to four
  typedef enum logic [1:0] {
    LAI_RNG_1 = 2'h0,
    LAI_RNG_2 = 2'h1,
    LAI_RNG_3 = 2'h2,
    LAI_RNG_4 = 2'h3
  } lai_range_t;

  // diode select codes
  typedef enum logic [1:0] {
    LAI_DSEL_VIS  = 2'h0,                           // visible_ir_photodiode only
    LAI_DSEL_IR   = 2'h1,                           // ir_photodiode only
    LAI_DSEL_DIFF = 2'h2,                           // differential_diode_sequence
    LAI_DSEL_NOP  = 2'h3                            // no operation
  } lai_dsel_t;

  // integration state
  typedef enum logic [0:0] {
    LAI_ST_IDLE  = 1'b0,
    LAI_ST_INTEG = 1'b1
  } lai_state_t;

  // decoded configuration
  typedef struct packed {
    logic       adc_en;
    logic       ext_mode;
    lai_dsel_t  dsel;
    lai_width_t width;
    lai_range_t range;
  } lai_cfg_t;

  // cycles per conversion for a width code
  function automatic logic [CNT_W-1:0] lai_cycles(input lai_width_t w);
    logic [CNT_W-1:0] c;
    c = 17'h10000;
    case (w)
      LAI_WID_16: c = 17'h10000;
      LAI_WID_12: c = 17'h01000;
      LAI_WID_8:  c = 17'h00100;
      LAI_WID_4:  c = 17'h00010;
      default:    c = 17'h10000;
    endcase
    return c;
  endfunction

endpackage

/* lai_top.sv */
// light adc integration timing and cycle count with an axi4-lite register slave
//
// Overview of operation
// (RULE1) command bit picks internal or external timing
// (RULE2) internal integration lasts two-to-the-n oscillator cycles
// (RULE3) internal duration set by count and oscillator
// (RULE4) internal full scale equals two-to-the-n
// (RULE5) four ranges, changes apply on next conversions; here a range write changes the rate of the running integration at once
// (RULE6) half rate in ranges one, two
// (RULE7) oscillator behaves same in both timing modes
// (RULE8) external single diode: sync starts integration
// (RULE9) external single diode: next sync stops it
// (RULE10) sync write ends and restarts integration immediately
// (RULE11) differential: syncs alternate visible then ir diode
// (RULE12) external count follows sync interval, capacity 65536
// (RULE13) external count stored as full scale reference
// (RULE14) host keeps sync spacing below counter capacity
// (RULE15) width codes give 65536, 4096, 256, 16 cycles
// (RULE16) timing bit zero internal, one external
// (RULE17) range codes 00 to 11 give range one-four
// (RULE18) diode codes: visible, ir, differential, no operation
// (RULE19) internal mode restarts integration right after completion
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module lai_top
(
  // clock and reset
  input  wire logic                             mclk_i,
  input  wire logic                             rst_i,
  // conversion oscillator, full rate, asynchronous
  input  wire logic                             osc_clk_i,
  // axi4-lite write address
  input  wire logic [lai_pkg::ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [lai_pkg::DATA_W-1:0]       s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // axi4-lite read address
  input  wire logic [lai_pkg::ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  // axi4-lite read data
  output logic [lai_pkg::DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // integration status towards the analog front end
  output logic                                  integ_active_o,
  output logic                                  ir_diode_sel_o,
  output logic                                  integ_done_o,
  output logic                                  osc_full_rate_o,
  output logic [lai_pkg::CNT_W-1:0]             full_scale_o
);

  // byte addresses of the registers
  localparam logic [lai_pkg::ADDR_W-1:0] A_CMD   = lai_pkg::IDX_CMD << lai_pkg::IDX_SHIFT;
  localparam logic [lai_pkg::ADDR_W-1:0] A_CTRL  = lai_pkg::IDX_CTRL << lai_pkg::IDX_SHIFT;
  localparam logic [lai_pkg::ADDR_W-1:0] A_TIMER = lai_pkg::IDX_TIMER << lai_pkg::IDX_SHIFT;
  localparam logic [lai_pkg::ADDR_W-1:0] A_SYNC  = lai_pkg::IDX_SYNC << lai_pkg::IDX_SHIFT;
  localparam logic [lai_pkg::ADDR_W-1:0] A_STAT  = lai_pkg::IDX_STAT << lai_pkg::IDX_SHIFT;

  // ---------------- register bus state ----------------
  logic                          awready_reg, awready_next;   // address slot free
  logic                          wready_reg, wready_next;     // data slot free
  logic [lai_pkg::ADDR_W-1:0]    awaddr_reg, awaddr_next;     // held write address
  logic [lai_pkg::DATA_W-1:0]    wdata_reg, wdata_next;       // held write data
  logic [3:0]                    wstrb_reg, wstrb_next;       // held strobes
  logic                          bvalid_reg, bvalid_next;     // write response pending
  logic [1:0]                    bresp_reg, bresp_next;       // write response code
  logic                          arready_reg, arready_next;   // read slot free
  logic                          rvalid_reg, rvalid_next;     // read data pending
  logic [lai_pkg::DATA_W-1:0]    rdata_reg, rdata_next;       // read data
  logic [1:0]                    rresp_reg, rresp_next;       // read response code
  logic [7:0]                    cmd_reg, cmd_next;           // command register
  logic [7:0]                    ctrl_reg, ctrl_next;         // control register
  logic                          sync_reg, sync_next;         // one-cycle sync strobe
  logic                          wr_go;                       // both halves held

  // ---------------- oscillator state ----------------
  logic                          osc_s1_reg, osc_s2_reg, osc_s3_reg; // synchroniser, edge history
  logic                          half_reg, half_next;         // divide-by-two phase
  logic                          tick_reg, tick_next;         // one oscillator increment
  logic                          rise;                        // full-rate edge seen

  // ---------------- integration state ----------------
  lai_pkg::lai_state_t           st_reg, st_next;             // idle or integrating
  logic [lai_pkg::CNT_W-1:0]     cnt_reg, cnt_next;           // increments so far
  logic [lai_pkg::CNT_W-1:0]     last_reg, last_next;         // count of last integration
  logic [lai_pkg::CNT_W-1:0]     fs_reg, fs_next;             // full scale reference
  logic                          ir_reg, ir_next;             // ir diode in use
  logic                          done_reg, done_next;         // end-of-integration pulse
  logic                          full_reg, full_next;         // full-rate indication
  logic [lai_pkg::CNT_W-1:0]     cnt_inc;                     // count including this tick
  logic [lai_pkg::CNT_W-1:0]     lai_lai_cycles_w;            // cycles per conversion for the width code
  lai_pkg::lai_cfg_t             cfg;                         // decoded configuration

  // configuration fields pulled from the registers
  always_comb
  begin
    cfg.adc_en   = cmd_reg[lai_pkg::CMD_EN_BIT];
    cfg.ext_mode = cmd_reg[lai_pkg::CMD_MODE_BIT];                                          // [RULE16]
    cfg.dsel     = lai_pkg::lai_dsel_t'(cmd_reg[lai_pkg::CMD_DSEL_LSB +: 2]);              // [RULE18]
    cfg.width    = lai_pkg::lai_width_t'(cmd_reg[lai_pkg::CMD_WID_LSB +: 2]);
    cfg.range    = lai_pkg::lai_range_t'(ctrl_reg[lai_pkg::CTRL_RNG_LSB +: 2]);            // [RULE17]
  end

  assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;

  // bus slave next state: write, read and register updates
  always_comb
  begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    cmd_next     = cmd_reg;
    ctrl_next    = ctrl_reg;
    sync_next    = 1'b0;
    // capture address and data in either order
    if (s_axi_awvalid && awready_reg)
    begin
      awaddr_next  = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      wready_next = 1'b0;
    end
    // perform the write once both are held
    if (wr_go)
    begin
      bvalid_next = 1'b1;
      bresp_next  = lai_pkg::RESP_OKAY;
      if (awaddr_reg == A_CMD)
      begin
        if (wstrb_reg[0])
        begin
          cmd_next = wdata_reg[7:0];                                                         // [RULE1]
        end
      end
      else if (awaddr_reg == A_CTRL)
      begin
        if (wstrb_reg[0])
        begin
          ctrl_next = wdata_reg[7:0];                                                        // [RULE5]
        end
      end
      else if (awaddr_reg == A_SYNC)
      begin
        sync_next = wstrb_reg[0] && wdata_reg[lai_pkg::SYNC_BIT];                           // [RULE10]
      end
      else if (awaddr_reg == A_TIMER || awaddr_reg == A_STAT)
      begin
        bresp_next = lai_pkg::RESP_OKAY;                                                     // read-only, ignored
      end
      else
      begin
        bresp_next = lai_pkg::RESP_SLVERR;                                                   // unmapped
      end
    end
    // release the write slots after the response is taken
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = lai_pkg::RESP_OKAY;
      rdata_next   = '0;
      if (s_axi_araddr == A_CMD)
      begin
        rdata_next[7:0] = cmd_reg;
      end
      else if (s_axi_araddr == A_CTRL)
      begin
        rdata_next[7:0] = ctrl_reg;
      end
      else if (s_axi_araddr == A_TIMER)
      begin
        rdata_next[15:0] = last_reg[15:0];                                                   // [RULE13]
      end
      else if (s_axi_araddr == A_SYNC)
      begin
        rdata_next = '0;                                                                     // strobe reads zero
      end
      else if (s_axi_araddr == A_STAT)
      begin
        rdata_next[lai_pkg::STAT_ACT_BIT]  = (st_reg == lai_pkg::LAI_ST_INTEG);
        rdata_next[lai_pkg::STAT_IR_BIT]   = ir_reg;
        rdata_next[lai_pkg::STAT_FULL_BIT] = full_reg;
        rdata_next[lai_pkg::STAT_SAT_BIT]  = last_reg[lai_pkg::CNT_W-1];
      end
      else
      begin
        rresp_next = lai_pkg::RESP_SLVERR;                                                   // unmapped
      end
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  // bus slave registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= lai_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= lai_pkg::RESP_OKAY;
      cmd_reg     <= lai_pkg::CMD_RST;
      ctrl_reg    <= lai_pkg::CTRL_RST;
      sync_reg    <= 1'b0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      cmd_reg     <= cmd_next;
      ctrl_reg    <= ctrl_next;
      sync_reg    <= sync_next;
    end
  end

  // only the synchronised copies feed the edge detector
  assign rise = osc_s2_reg && !osc_s3_reg;

  // oscillator divider: every edge at full rate, every second edge in ranges one and two
  always_comb
  begin
    full_next = (cfg.range == lai_pkg::LAI_RNG_3) || (cfg.range == lai_pkg::LAI_RNG_4);     // [RULE6]
    half_next = half_reg;
    tick_next = 1'b0;
    if (rise)
    begin
      half_next = !half_reg;
      tick_next = full_reg || half_reg;                                                      // [RULE6] [RULE7]
    end
  end

  // oscillator synchroniser and divider registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      half_reg   <= 1'b0;
      tick_reg   <= 1'b0;
      full_reg   <= 1'b0;
    end
    else
    begin
      osc_s1_reg <= osc_clk_i;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      half_reg   <= half_next;
      tick_reg   <= tick_next;
      full_reg   <= full_next;
    end
  end

  // increments including the current tick, held at capacity
  assign cnt_inc = (tick_reg && cnt_reg != lai_pkg::CNT_CAP) ? cnt_reg + 17'h00001 : cnt_reg; // [RULE12]

  // integration sequencer next state
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    last_next = last_reg;
    fs_next   = fs_reg;
    ir_next   = ir_reg;
    done_next = 1'b0;
    case (st_reg)
      lai_pkg::LAI_ST_IDLE:
      begin
        cnt_next = '0;
        ir_next  = (cfg.dsel == lai_pkg::LAI_DSEL_IR);                                       // differential starts visible [RULE11]
        if (cfg.adc_en && cfg.dsel != lai_pkg::LAI_DSEL_NOP)                                 // [RULE18]
        begin
          if (!cfg.ext_mode || sync_reg)                                                     // [RULE8] [RULE1]
          begin
            st_next = lai_pkg::LAI_ST_INTEG;
          end
        end
      end
      lai_pkg::LAI_ST_INTEG:
      begin
        cnt_next = cnt_inc;
        if (!cfg.adc_en || cfg.dsel == lai_pkg::LAI_DSEL_NOP)
        begin
          st_next  = lai_pkg::LAI_ST_IDLE;                                                   // abandon, nothing stored
          cnt_next = '0;
        end
        else if (cfg.ext_mode)
        begin
          if (sync_reg)                                                                      // [RULE9] [RULE10]
          begin
            done_next = 1'b1;
            last_next = cnt_inc;                                                             // [RULE12] [RULE14]
            fs_next   = cnt_inc;                                                             // [RULE13]
            cnt_next  = '0;                                                                  // no idle gap
            if (cfg.dsel == lai_pkg::LAI_DSEL_DIFF)
            begin
              ir_next = !ir_reg;                                                             // [RULE11]
            end
          end
        end
        else if (tick_reg && cnt_inc == lai_lai_cycles_w)                                    // [RULE2] [RULE3] [RULE15]
        begin
          done_next = 1'b1;
          last_next = cnt_inc;
          fs_next   = lai_lai_cycles_w;                                                      // [RULE4]
          cnt_next  = '0;                                                                    // [RULE19]
          if (cfg.dsel == lai_pkg::LAI_DSEL_DIFF)
          begin
            ir_next = !ir_reg;
          end
        end
      end
      default:
      begin
        st_next = lai_pkg::LAI_ST_IDLE;
      end
    endcase
  end

  // cycles per conversion for the programmed width
  assign lai_lai_cycles_w = lai_pkg::lai_cycles(cfg.width);                                 // [RULE15]

  // integration sequencer registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_reg   <= lai_pkg::LAI_ST_IDLE;
      cnt_reg  <= '0;
      last_reg <= '0;
      fs_reg   <= '0;
      ir_reg   <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      last_reg <= last_next;
      fs_reg   <= fs_next;
      ir_reg   <= ir_next;
      done_reg <= done_next;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready   = awready_reg;
  assign s_axi_wready    = wready_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_arready   = arready_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
  assign integ_active_o  = (st_reg == lai_pkg::LAI_ST_INTEG);
  assign ir_diode_sel_o  = ir_reg;
  assign integ_done_o    = done_reg;
  assign osc_full_rate_o = full_reg;
  assign full_scale_o    = fs_reg;

endmodule

/* lai_top_asserts.sv */
// port-level assertions for the integration timing block
module lai_top_asserts
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // integration status
  input wire logic        integ_active_o,
  input wire logic        integ_done_o,
  input wire logic [16:0] full_scale_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // both write channels taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // slots closed, then the response one edge later
  sequence s_wr_answer;
    !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_wr_walk: assert property (s_wr_take |=> s_wr_answer)
    else $error("write response not two edges after take");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write slot not reopened after response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after take");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read slot not reopened after data");
  a_done_pulse: assert property (integ_done_o |=> !integ_done_o)
    else $error("done pulse longer than one cycle");
  a_done_active: assert property (integ_done_o |-> $past(integ_active_o))
    else $error("done without a running integration");
  a_fs_on_done: assert property ($changed(full_scale_o) |-> integ_done_o)
    else $error("full scale changed without done");
  a_fs_cap: assert property (full_scale_o <= lai_pkg::CNT_CAP)
    else $error("full scale above counter capacity");
endmodule

bind lai_top lai_top_asserts i_lai_top_asserts (.*);

/* lai_osc_src.sv */
// conversion oscillator model feeding the block at full rate
module lai_osc_src #(parameter int HALF_NS = 80)
(
  // oscillator output
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // free running: the oscillator never stops between integrations
  initial osc_o = 1'b0;
  always #(HALF_NS) osc_o = ~osc_o;
endmodule

/* testbench.sv */
// self-checking bench for the integration timing block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CMD  = lai_pkg::IDX_CMD << lai_pkg::IDX_SHIFT;
  localparam logic [7:0] A_CTRL = lai_pkg::IDX_CTRL << lai_pkg::IDX_SHIFT;
  localparam logic [7:0] A_TMR  = lai_pkg::IDX_TIMER << lai_pkg::IDX_SHIFT;
  localparam logic [7:0] A_SYNC = lai_pkg::IDX_SYNC << lai_pkg::IDX_SHIFT;
  localparam logic [7:0] A_STAT = lai_pkg::IDX_STAT << lai_pkg::IDX_SHIFT;
  localparam logic [1:0] OK     = lai_pkg::RESP_OKAY;
  localparam logic [1:0] ERR    = lai_pkg::RESP_SLVERR;
  // design signals
  logic        mclk_i = 1'b0, rst_i = 1'b1;
  wire logic   osc_clk_i;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        integ_active_o, ir_diode_sel_o, integ_done_o, osc_full_rate_o;
  logic [16:0] full_scale_o;
  int          err_total = 0, n_compared = 0, cyc = 0, ndone = 0, tlast = 0, tprev = 0, t0, k, d;

  lai_top i_lai_top (.*);
  lai_osc_src i_lai_osc_src (.osc_o(osc_clk_i));
  always #4 mclk_i = ~mclk_i;

  // cycle count, done log and hang guard
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (integ_done_o)
    begin
      ndone <= ndone + 1;
      tprev <= tlast;
      tlast <= cyc;
    end
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end

  // verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // exact value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
      err_total++;
    end
  endtask

  // window compare for oscillator-derived counts
  task automatic chk_win(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      $display("[ERR] %s exp %0d..%0d got %0h", nm, lo, hi, g);
      err_total++;
    end
  endtask

  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
    bit fin;
    fin = 0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dv;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!fin)
    begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        fin = 1;
      end
    end
  endtask

  // bus read, data handed back
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    bit fin;
    fin = 0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!fin)
    begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        chk("rresp", er, s_axi_rresp);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        fin = 1;
      end
    end
  endtask

  // sync strobe, then let it take effect
  task automatic sync_pulse;
    wr(A_SYNC, 32'h1, OK);
    repeat (4) @(posedge mclk_i);
  endtask

  // internal run: length of one full integration and its full scale
  task automatic intl(input logic [7:0] cmd, input int n, input int per);
    int c;
    wr(A_CMD, 32'h0, OK);
    c = ndone;
    wr(A_CMD, {24'h0, cmd}, OK);
    wait (ndone == c + 3);
    @(negedge mclk_i);
    chk_win("period", n * per - 3, n * per + 3, tlast - tprev);
    chk("full_scale", n, full_scale_o);
    chk("active", 1, integ_active_o);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(A_CMD, OK, rv);
    chk("cmd_rst", 0, rv);
    rd(A_CTRL, OK, rv);
    chk("ctrl_rst", 0, rv);
    rd(8'h3C, ERR, rv);
    chk("unmapped", 0, rv);
    wr(8'h3C, 32'hFF, ERR);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_CTRL, 32'(i << 2), OK);
      repeat (60) @(posedge mclk_i);
      chk("full_rate", i >= 2, osc_full_rate_o);
    end
    intl(8'h83, 16, 20);
    intl(8'h82, 256, 20);
    wr(A_CTRL, 32'h0, OK);
    intl(8'h83, 16, 40);
    // external timing, single diode, half rate
    wr(A_CMD, 32'h0, OK);
    wr(A_CMD, 32'hA0, OK);
    repeat (100) @(posedge mclk_i);
    chk("ext_idle", 0, integ_active_o);
    t0 = cyc;
    sync_pulse();
    chk("ext_run", 1, integ_active_o);
    repeat (2000) @(posedge mclk_i); // spacing far below counter capacity
    k = ndone;
    sync_pulse();
    d = (cyc - t0) / 40;
    chk("ext_done", k + 1, ndone);
    chk_win("ext_count", d - 2, d + 2, full_scale_o);
    rd(A_TMR, OK, rv);
    chk_win("timer", d - 2, d + 2, rv);
    chk("restart", 1, integ_active_o);
    rd(A_STAT, OK, rv);
    chk("status", 32'h1, rv);
    // differential sequence: visible, ir, visible
    wr(A_CMD, 32'h0, OK);
    wr(A_CMD, 32'hA8, OK);
    for (int i = 0; i < 3; i++)
    begin
      sync_pulse();
      chk("diode", i % 2, ir_diode_sel_o);
      repeat (200) @(posedge mclk_i);
    end
    // no-operation diode code
    wr(A_CMD, 32'h0, OK);
    k = ndone;
    wr(A_CMD, 32'h8F, OK);
    repeat (800) @(posedge mclk_i);
    chk("nop_idle", 0, integ_active_o);
    chk("nop_done", k, ndone);
    complete_run();
  end
endmodule
